// ---- pkg/pipe_timing_pkg.sv ----
// types and timing figures for the five-stage pipeline timing block
// assumes one 50 MHz core clock; the bus rate is an enable derived from it
//
// Behaviour
// - five stages; branch delays next fetch, decode, execute
// - load: decode 1, execute 1, read, writeback 1
// - store: decode 1, execute 1, write, no writeback
// - multiply executes 3 cycles, divide 37 cycles
// - other instructions: one cycle each, no access
// - instruction queue hit fetches in one cycle
// - internal rom or ram read: one cycle
// - register area read: 2 narrow, 4 word
// - external read: 1 core plus 2/4 bus
// - back-to-back external fetch: 4 bus cycles
// - internal ram write: one cycle
// - register area write: 2 narrow, 4 word
// - external write: 2 narrow, 4 word bus
// - external access carries at least one wait
// - bus clock is half the core clock
// - store ends in write buffer, write follows later
package pipe_timing_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [1:0] BUS_CLOCK_DIV      = 2'h2;
    localparam logic [5:0] EXEC_ONE_CYCLES    = 6'h01;
    localparam logic [5:0] EXEC_MUL_CYCLES    = 6'h03;
    localparam logic [5:0] EXEC_DIV_CYCLES    = 6'h25;
    localparam logic [3:0] QUEUE_CORE_CYCLES  = 4'h1;
    localparam logic [3:0] INT_RD_CORE_CYCLES = 4'h1;
    localparam logic [3:0] INT_WR_CORE_CYCLES = 4'h1;
    localparam logic [3:0] SFR_NARROW_CYCLES  = 4'h2;
    localparam logic [3:0] SFR_WORD_CYCLES    = 4'h4;
    localparam logic [3:0] EXT_RD_CORE_CYCLES = 4'h1;
    localparam logic [3:0] EXT_NARROW_BUS     = 4'h2;
    localparam logic [3:0] EXT_WORD_BUS       = 4'h4;
    localparam logic [3:0] EXT_SEQ_FETCH_BUS  = 4'h4;

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        CLS_LOAD,
        CLS_STORE,
        CLS_MUL,
        CLS_DIV,
        CLS_OTHER
    } instr_class_t;

    typedef enum logic [1:0] {
        RGN_QUEUE,
        RGN_INTERNAL,
        RGN_SFR,
        RGN_EXTERNAL
    } mem_region_t;

    typedef struct packed {
        mem_region_t region;
        logic        word;
    } access_t;

    typedef struct packed {
        instr_class_t cls;
        logic         branch;
        access_t      fetch;
        access_t      data;
    } instr_t;

    typedef struct packed {
        logic [3:0] core;
        logic [3:0] bus;
    } timing_t;

endpackage

// ---- design/pipeline_timing.sv ----
// five-stage pipeline timing model: stage occupancy, access minimums, write buffer
// assumes memory acknowledges come from logic on the same clock, held until taken
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// minimum access timer: core cycles first, then bus cycles counted on the bus enable
module access_timer
    import pipe_timing_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    rst,
    input  wire logic    bclk_en,
    input  wire logic    load,
    input  wire timing_t need,
    output logic         done
);

    logic [3:0] core_left;
    logic [3:0] bus_left;
    logic       bus_armed;

    // a bus pulse counts only when the cycle before it already belonged to the
    // bus part, so each counted pulse closes a whole bus period inside the access;
    // an access that starts mid-period therefore runs one core cycle longer
    wire bus_phase = (core_left == 4'h0) && (bus_left != 4'h0);
    wire bus_tick  = bclk_en && bus_armed;
    wire core_last = (core_left <= 4'h1) && (bus_left == 4'h0);
    wire bus_last  = (core_left == 4'h0) && (bus_left == 4'h1) && bus_tick;
    wire idle      = (core_left == 4'h0) && (bus_left == 4'h0);

    assign done = core_last || bus_last || idle;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_left <= 4'h0;
            bus_left  <= 4'h0;
            bus_armed <= 1'b0;
        end else if (load) begin
            core_left <= need.core;
            bus_left  <= need.bus;
            bus_armed <= 1'b0;
        end else if (core_left != 4'h0) begin
            core_left <= core_left - 4'h1;
        end else if (bus_phase) begin
            bus_armed <= 1'b1;
            if (bus_tick) begin
                bus_left <= bus_left - 4'h1;
            end
        end
    end

endmodule // access_timer

////////////////////////////////////////////////////////////////////////////////
module pipeline_timing
    import pipe_timing_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         instr_valid,
    output logic              instr_ready,
    input  wire instr_t       instr,
    output logic              fetch_req,
    output access_t           fetch_access,
    input  wire logic         fetch_ack,
    output logic              rd_req,
    output access_t           rd_access,
    input  wire logic         rd_ack,
    output logic              wr_req,
    output access_t           wr_access,
    input  wire logic         wr_ack,
    output logic              bus_clock_en,
    output logic [4:0]        stage_busy,
    output logic              regfile_write,
    output logic              retire_valid,
    output instr_class_t      retire_class
);

    ////////////////////////////////////////////////////////////////////////////////
    // figures per instruction class and per access

    function automatic logic [5:0] exec_cycles(input instr_class_t cls);
        logic [5:0] n;
        n = EXEC_ONE_CYCLES;
        if (cls == CLS_MUL) begin
            n = EXEC_MUL_CYCLES;
        end else if (cls == CLS_DIV) begin
            n = EXEC_DIV_CYCLES;
        end
        return n;
    endfunction

    // external figures already include the one mandatory wait cycle
    function automatic timing_t access_need(input access_t a, input logic write, input logic seq);
        timing_t t;
        t = '0;
        case (a.region)
            RGN_QUEUE: begin
                t.core = QUEUE_CORE_CYCLES;
            end
            RGN_INTERNAL: begin
                t.core = write ? INT_WR_CORE_CYCLES : INT_RD_CORE_CYCLES;
            end
            RGN_SFR: begin
                t.core = a.word ? SFR_WORD_CYCLES : SFR_NARROW_CYCLES;
            end
            RGN_EXTERNAL: begin
                if (write) begin
                    t.bus = a.word ? EXT_WORD_BUS : EXT_NARROW_BUS;
                end else if (seq) begin
                    t.bus = EXT_SEQ_FETCH_BUS;
                end else begin
                    t.core = EXT_RD_CORE_CYCLES;
                    t.bus  = a.word ? EXT_WORD_BUS : EXT_NARROW_BUS;
                end
            end
            default: begin
                t.core = INT_RD_CORE_CYCLES;
            end
        endcase
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // bus clock enable: one pulse every second core cycle
    // the divider free-runs from reset; bus parts of an access align to it

    logic [1:0] div_cnt;

    wire div_wrap = (div_cnt == BUS_CLOCK_DIV - 2'h1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt <= 2'h0;
        end else begin
            div_cnt <= div_wrap ? 2'h0 : div_cnt + 2'h1;
        end
    end

    assign bus_clock_en = div_wrap;

    ////////////////////////////////////////////////////////////////////////////////
    // stage registers

    logic       if_valid;
    instr_t     if_ins;
    logic       d_valid;
    instr_t     d_ins;
    logic       ex_valid;
    instr_t     ex_ins;
    logic [5:0] ex_left;
    logic       mem_valid;
    instr_t     mem_ins;
    logic       wb_valid;
    instr_t     wb_ins;
    logic       wbuf_valid;
    access_t    wbuf_acc;

    logic if_timer_done;
    logic mem_timer_done;
    logic wbuf_timer_done;

    ////////////////////////////////////////////////////////////////////////////////
    // advance conditions, from the back of the pipe forward

    wire mem_is_load  = mem_ins.cls == CLS_LOAD;
    wire mem_is_store = mem_ins.cls == CLS_STORE;
    wire ex_is_load   = ex_ins.cls == CLS_LOAD;

    wire wbuf_done = wbuf_valid && wbuf_timer_done && wr_ack;

    // a store leaves the memory stage as soon as the buffer can take it
    wire store_done = !wbuf_valid || wbuf_done;
    wire load_done  = mem_timer_done && rd_ack;
    wire mem_go     = mem_valid && (mem_is_load ? load_done :
                                    mem_is_store ? store_done : 1'b1);
    wire mem_free   = !mem_valid || mem_go;

    // a pending buffered write delays the next read
    wire ex_done = ex_valid && (ex_left == 6'h00);
    wire ex_go   = ex_done && mem_free && !(ex_is_load && wbuf_valid);
    wire ex_free = !ex_valid || ex_go;

    wire d_go   = d_valid && ex_free;
    wire d_free = !d_valid || d_go;

    wire if_done = if_valid && if_timer_done && fetch_ack;
    wire if_go   = if_done && d_free;

    // the next fetch waits until a branch has left execute
    wire branch_hold = (if_valid && if_ins.branch) ||
                       (d_valid && d_ins.branch) ||
                       (ex_valid && ex_ins.branch);

    assign instr_ready = (!if_valid || if_go) && !branch_hold;

    wire accept = instr_valid && instr_ready;

    wire seq_fetch = if_go && (if_ins.fetch.region == RGN_EXTERNAL) &&
                     (instr.fetch.region == RGN_EXTERNAL);

    wire     mem_load_start = ex_go && ex_is_load;
    wire     wbuf_load      = mem_go && mem_is_store;
    timing_t if_need;
    timing_t mem_need;
    timing_t wbuf_need;

    assign if_need   = access_need(instr.fetch, 1'b0, seq_fetch);
    assign mem_need  = access_need(ex_ins.data, 1'b0, 1'b0);
    assign wbuf_need = access_need(mem_ins.data, 1'b1, 1'b0);

    ////////////////////////////////////////////////////////////////////////////////
    // access timers
    // each timer is loaded on the edge that launches its request, so its first
    // counted cycle is the first cycle in which that request stands

    access_timer u_if_timer (
        .clk     (clk),
        .rst     (rst),
        .bclk_en (bus_clock_en),
        .load    (accept),
        .need    (if_need),
        .done    (if_timer_done)
    );

    access_timer u_mem_timer (
        .clk     (clk),
        .rst     (rst),
        .bclk_en (bus_clock_en),
        .load    (mem_load_start),
        .need    (mem_need),
        .done    (mem_timer_done)
    );

    access_timer u_wbuf_timer (
        .clk     (clk),
        .rst     (rst),
        .bclk_en (bus_clock_en),
        .load    (wbuf_load),
        .need    (wbuf_need),
        .done    (wbuf_timer_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // fetch and decode

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            if_valid <= 1'b0;
            if_ins   <= '0;
        end else if (accept) begin
            if_valid <= 1'b1;
            if_ins   <= instr;
        end else if (if_go) begin
            if_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            d_valid <= 1'b0;
            d_ins   <= '0;
        end else if (if_go) begin
            d_valid <= 1'b1;
            d_ins   <= if_ins;
        end else if (d_go) begin
            d_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // execute

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ex_valid <= 1'b0;
            ex_ins   <= '0;
            ex_left  <= 6'h00;
        end else if (d_go) begin
            ex_valid <= 1'b1;
            ex_ins   <= d_ins;
            ex_left  <= exec_cycles(d_ins.cls) - 6'h01;
        end else if (ex_go) begin
            ex_valid <= 1'b0;
        end else if (ex_valid && ex_left != 6'h00) begin
            ex_left <= ex_left - 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // memory stage, writeback and write buffer
    // a store in the buffer keeps wr_req up until its minimum has run and the
    // memory side has taken it

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_valid <= 1'b0;
            mem_ins   <= '0;
        end else if (ex_go) begin
            mem_valid <= 1'b1;
            mem_ins   <= ex_ins;
        end else if (mem_go) begin
            mem_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_valid <= 1'b0;
            wb_ins   <= '0;
        end else begin
            wb_valid <= mem_go;
            wb_ins   <= mem_ins;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wbuf_valid <= 1'b0;
            wbuf_acc   <= '0;
        end else if (wbuf_load) begin
            wbuf_valid <= 1'b1;
            wbuf_acc   <= mem_ins.data;
        end else if (wbuf_done) begin
            wbuf_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    // fetch_req and wr_req come straight from stage registers, so they never glitch; rd_req gates mem_valid with a decode of mem_ins

    assign fetch_req     = if_valid;
    assign fetch_access  = if_ins.fetch;
    assign rd_req        = mem_valid && mem_is_load;
    assign rd_access     = mem_ins.data;
    assign wr_req        = wbuf_valid;
    assign wr_access     = wbuf_acc;
    assign stage_busy    = {if_valid, d_valid, ex_valid, mem_valid, wb_valid};
    assign regfile_write = wb_valid && (wb_ins.cls != CLS_STORE);
    assign retire_valid  = wb_valid;
    assign retire_class  = wb_ins.cls;

endmodule // pipeline_timing

// ---- sim/pipeline_timing_checker.sv ----
// checker for the pipeline timing block: timing relations seen at its ports
// assumes one clock and an asynchronous active-high reset; bound below
`timescale 1ns/1ps
module pipeline_timing_checker
    import pipe_timing_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst,
    input wire logic         fetch_req,
    input wire access_t      fetch_access,
    input wire logic         fetch_ack,
    input wire logic         rd_req,
    input wire access_t      rd_access,
    input wire logic         rd_ack,
    input wire logic         wr_req,
    input wire access_t      wr_access,
    input wire logic         bus_clock_en,
    input wire logic [4:0]   stage_busy,
    input wire logic         regfile_write,
    input wire logic         retire_valid,
    input wire instr_class_t retire_class
);
    logic [7:0] fc;
    logic [7:0] rc;
    logic [7:0] wc;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // minimum length of an access in core cycles
    function automatic int mc(access_t a, logic wr);
        case (a.region)
            RGN_SFR:      return a.word ? 4 : 2;
            RGN_EXTERNAL: return (a.word ? 8 : 4) + (wr ? 0 : 1);
            default:      return 1;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fc <= 8'h00;
            rc <= 8'h00;
            wc <= 8'h00;
        end else begin
            fc <= fetch_req ? fc + 8'h01 : 8'h00;
            rc <= rd_req ? rc + 8'h01 : 8'h00;
            wc <= wr_req ? wc + 8'h01 : 8'h00;
        end
    end
    property p_bus_half;
        bus_clock_en |=> !bus_clock_en ##1 bus_clock_en;
    endproperty
    a_bus_half: assert property (p_bus_half) else $error("bus enable not one in two");
    property p_wb_write;
        regfile_write == (retire_valid && retire_class != CLS_STORE);
    endproperty
    a_wb_write: assert property (p_wb_write) else $error("writeback pulse wrong");
    property p_rd_in_mem;
        rd_req |-> stage_busy[1];
    endproperty
    a_rd_in_mem: assert property (p_rd_in_mem) else $error("read outside memory stage");
    property p_fetch_hold;
        fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_access);
    endproperty
    a_fetch_hold: assert property (p_fetch_hold) else $error("fetch left without ack");
    property p_rd_hold;
        rd_req && !rd_ack |=> rd_req && $stable(rd_access);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read left without ack");
    property p_fetch_min;
        $fell(fetch_req) |-> fc >= mc($past(fetch_access), 1'b0);
    endproperty
    a_fetch_min: assert property (p_fetch_min) else $error("fetch too short");
    property p_rd_min;
        $fell(rd_req) |-> rc >= mc($past(rd_access), 1'b0);
    endproperty
    a_rd_min: assert property (p_rd_min) else $error("read too short");
    property p_wr_min;
        $fell(wr_req) |-> wc >= mc($past(wr_access), 1'b1);
    endproperty
    a_wr_min: assert property (p_wr_min) else $error("write too short");
endmodule // pipeline_timing_checker

bind pipeline_timing pipeline_timing_checker i_chk (
    .clk(clk), .rst(rst), .fetch_req(fetch_req), .fetch_access(fetch_access), .fetch_ack(fetch_ack),
    .rd_req(rd_req), .rd_access(rd_access), .rd_ack(rd_ack), .wr_req(wr_req), .wr_access(wr_access),
    .bus_clock_en(bus_clock_en), .stage_busy(stage_busy), .regfile_write(regfile_write),
    .retire_valid(retire_valid), .retire_class(retire_class)
);

// ---- sim/mem_partner.sv ----
// memory side model: acknowledges each request after lat cycles of waiting
// assumes requests change just after the rising clock edge
`timescale 1ns/1ps
module mem_partner (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] lat,
    input  wire logic       fetch_req,
    input  wire logic       rd_req,
    input  wire logic       wr_req,
    output logic            fetch_ack,
    output logic            rd_ack,
    output logic            wr_ack
);
    logic [3:0] fcnt;
    logic [3:0] rcnt;
    logic [3:0] wcnt;
    ////////////////////////////////////////////////////////////////////////////////
    // acks stay low when nothing is asked
    assign fetch_ack = fetch_req && fcnt >= lat;
    assign rd_ack    = rd_req && rcnt >= lat;
    assign wr_ack    = wr_req && wcnt >= lat;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fcnt <= 4'h0;
            rcnt <= 4'h0;
            wcnt <= 4'h0;
        end else begin
            fcnt <= (fetch_req && !fetch_ack) ? fcnt + {3'h0, fcnt < lat} : 4'h0;
            rcnt <= (rd_req && !rd_ack) ? rcnt + {3'h0, rcnt < lat} : 4'h0;
            wcnt <= (wr_req && !wr_ack) ? wcnt + {3'h0, wcnt < lat} : 4'h0;
        end
    end
endmodule // mem_partner

// ---- sim/pipeline_timing_tb.sv ----
// testbench for the pipeline timing block: stage and access lengths
// assumes the memory model answers after lat cycles
`timescale 1ns/1ps
module pipeline_timing_tb;
    import pipe_timing_pkg::*;
    typedef struct {instr_class_t c; access_t f, d; int s, lo, hi;} case_t;
    localparam access_t QN = '{RGN_QUEUE, 1'b0};
    localparam access_t IN = '{RGN_INTERNAL, 1'b0};
    localparam access_t SN = '{RGN_SFR, 1'b0};
    localparam access_t SW = '{RGN_SFR, 1'b1};
    localparam access_t EN = '{RGN_EXTERNAL, 1'b0};
    localparam access_t EW = '{RGN_EXTERNAL, 1'b1};
    logic         clk, rst, instr_valid, instr_ready, fetch_req, fetch_ack, rd_req, rd_ack, wr_req, wr_ack;
    logic         bus_clock_en, regfile_write, retire_valid;
    logic [4:0]   stage_busy;
    logic [3:0]   lat;
    instr_t       instr;
    access_t      fetch_access, rd_access, wr_access;
    instr_class_t retire_class;
    logic [7:0]   mon;
    int           cur[8], len[8];
    int           cyc = 0, nret = 0, nrf = 0, nbce = 0, acc_t = 0, err_count = 0, compares = 0;
    pipeline_timing i_dut (
        .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready), .instr(instr),
        .fetch_req(fetch_req), .fetch_access(fetch_access), .fetch_ack(fetch_ack), .rd_req(rd_req),
        .rd_access(rd_access), .rd_ack(rd_ack), .wr_req(wr_req), .wr_access(wr_access), .wr_ack(wr_ack),
        .bus_clock_en(bus_clock_en), .stage_busy(stage_busy), .regfile_write(regfile_write),
        .retire_valid(retire_valid), .retire_class(retire_class)
    );
    mem_partner i_mem (
        .clk(clk), .rst(rst), .lat(lat), .fetch_req(fetch_req), .rd_req(rd_req), .wr_req(wr_req),
        .fetch_ack(fetch_ack), .rd_ack(rd_ack), .wr_ack(wr_ack)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // run lengths of requests and stage occupancy, ended runs kept in len
    assign mon = {fetch_req, rd_req, wr_req, stage_busy};
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        nret <= nret + (retire_valid === 1'b1);
        nrf <= nrf + (regfile_write === 1'b1);
        nbce <= nbce + (bus_clock_en === 1'b1);
        for (int i = 0; i < 8; i++) begin
            cur[i] <= (mon[i] === 1'b1) ? cur[i] + 1 : 0;
            if (!mon[i] && cur[i] != 0) len[i] <= cur[i];
        end
        if (cyc == 20000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic check(int got, int lo, int hi);
        compares++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("MISMATCH t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
        end
    endtask
    task automatic issue(instr_class_t c, logic b, access_t f, access_t d, logic h = 1'b0);
        @(negedge clk);
        instr <= '{c, b, f, d};
        instr_valid <= 1'b1;
        for (int n = 0; n < 200 && instr_ready !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        acc_t = cyc;
        if (!h) @(negedge clk) instr_valid <= 1'b0;
    endtask
    task automatic drain();
        for (int n = 0; n < 200 && (stage_busy !== 5'h00 || wr_req !== 1'b0); n++) @(negedge clk);
        @(negedge clk);
    endtask
    task automatic t_bus();
        int n0 = nbce;
        repeat (20) @(negedge clk);
        check(nbce - n0, 10, 10);
    endtask
    task automatic t_classes();
        instr_class_t cl[5] = '{CLS_OTHER, CLS_MUL, CLS_DIV, CLS_LOAD, CLS_STORE};
        int ex[5] = '{1, 3, 37, 1, 1};
        int r0, w0;
        for (int k = 0; k < 5; k++) begin
            r0 = nret;
            w0 = nrf;
            issue(cl[k], 1'b0, IN, IN);
            drain();
            check(len[2], ex[k], ex[k]);
            check(len[3], 1, 1);
            check(nrf - w0, cl[k] != CLS_STORE, cl[k] != CLS_STORE);
            check(nret - r0, 1, 1);
        end
    endtask
    task automatic t_access();
        case_t tab[14] = '{
            '{CLS_OTHER, QN, IN, 7, 1, 1}, '{CLS_OTHER, SN, IN, 7, 2, 2}, '{CLS_OTHER, SW, IN, 7, 4, 4},
            '{CLS_OTHER, EW, IN, 7, 9, 10}, '{CLS_LOAD, IN, IN, 6, 1, 1}, '{CLS_LOAD, IN, SN, 6, 2, 2},
            '{CLS_LOAD, IN, SW, 6, 4, 4}, '{CLS_LOAD, IN, EN, 6, 5, 6}, '{CLS_LOAD, IN, EW, 6, 9, 10},
            '{CLS_STORE, IN, IN, 5, 1, 1}, '{CLS_STORE, IN, SN, 5, 2, 2}, '{CLS_STORE, IN, SW, 5, 4, 4},
            '{CLS_STORE, IN, EN, 5, 4, 5}, '{CLS_STORE, IN, EW, 5, 8, 9}};
        foreach (tab[k]) begin
            issue(tab[k].c, 1'b0, tab[k].f, tab[k].d);
            drain();
            check(len[tab[k].s], tab[k].lo, tab[k].hi);
        end
    endtask
    task automatic t_store_buffer();
        issue(CLS_STORE, 1'b0, IN, EW);
        for (int n = 0; n < 50 && retire_valid !== 1'b1; n++) @(negedge clk);
        check(wr_req === 1'b1, 1, 1);
        drain();
        check(len[1], 1, 1);
    endtask
    task automatic t_pairs();
        int a0;
        issue(CLS_OTHER, 1'b0, EW, IN, 1'b1);
        a0 = acc_t;
        issue(CLS_OTHER, 1'b0, EW, IN);
        drain();
        check(acc_t - a0, 9, 10);
        check(len[7] - (acc_t - a0), 8, 9);
        issue(CLS_OTHER, 1'b0, IN, IN, 1'b1);
        a0 = acc_t;
        issue(CLS_OTHER, 1'b0, IN, IN);
        drain();
        check(acc_t - a0, 1, 1);
        issue(CLS_OTHER, 1'b1, IN, IN, 1'b1);
        a0 = acc_t;
        issue(CLS_OTHER, 1'b0, IN, IN);
        drain();
        check(acc_t - a0, 3, 5);
    endtask
    task automatic t_stall();
        lat <= 4'h3;
        issue(CLS_LOAD, 1'b0, IN, IN);
        drain();
        check(len[7], 4, 4);
        check(len[6], 4, 4);
        lat <= 4'h0;
    endtask
    task automatic print_verdict();
        if (err_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        lat = 4'h0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_bus();
        t_classes();
        t_access();
        t_store_buffer();
        t_pairs();
        t_stall();
        print_verdict();
    end
endmodule // pipeline_timing_tb
